// ---- design/ssip_map.svh ----
// constants for the position link slave: frame layout, field widths, timing
`ifndef SSIP_MAP_SVH
`define SSIP_MAP_SVH

// frame and position field layout
`define SSIP_FRAME_BITS 25
`define SSIP_POS_BITS 20
`define SSIP_CNT_BITS 5

// position field width per resolution variant (coarsest to finest step)
`define SSIP_WIDTH_STEP100 5'h10
`define SSIP_WIDTH_STEP50 5'h11
`define SSIP_WIDTH_STEP10 5'h13
`define SSIP_WIDTH_STEP5 5'h14

// resolution select codes as strapped on the variant pins
`define SSIP_RES_STEP100 2'h0
`define SSIP_RES_STEP50 2'h1
`define SSIP_RES_STEP10 2'h2
`define SSIP_RES_STEP5 2'h3

// system clock and latch_timeout (monoflop) interval
`define SSIP_CLK_MHZ 100
`define SSIP_LATCH_TIMEOUT_NS 12000
`define SSIP_LATCH_CYC ((`SSIP_LATCH_TIMEOUT_NS * `SSIP_CLK_MHZ) / 1000)
`define SSIP_MONO_W 11

// reset values
`define SSIP_RST_SDATA 1'h1
`define SSIP_RST_LED 1'h1

`endif

// ---- design/ssip_pkg.sv ----
// types shared by the position link slave and its frame buffer
package ssip_pkg;
	`include "ssip_map.svh"

	// link sequencer states
	typedef enum logic [1:0] {LNK_LATCH, LNK_IDLE, LNK_SHIFT} ssip_link_t;

	// whole state of the slave top
	typedef struct packed {
		logic sclkMeta;
		logic sclkSync;
		logic sclkPrev;
		logic zeroMeta;
		logic zeroSync;
		logic zeroPrev;
		logic dirMeta;
		logic dirSync;
		logic [1:0] resMeta;
		logic [1:0] resSync;
		ssip_link_t link;
		logic [`SSIP_CNT_BITS-1:0] bitsLeft;
		logic [`SSIP_MONO_W-1:0] monoCnt;
		logic [`SSIP_FRAME_BITS-1:0] shiftReg;
		logic sdata;
		logic [`SSIP_POS_BITS-1:0] offset;
		logic [`SSIP_POS_BITS-1:0] heldPos;
		logic validSeen;
		logic errLed;
		logic pushReq;
		logic busy;
	} ssip_state_t;

	// whole state of the two-entry frame buffer
	typedef struct packed {
		logic [1:0][`SSIP_FRAME_BITS-1:0] mem;
		logic [1:0] fill;
	} ssip_buf_t;
endpackage

// ---- design/ssip_buffer.sv ----
// two-entry frame buffer between the position latch and the link shifter
`timescale 1ns/1ps
`include "ssip_map.svh"
module ssip_buffer
	import ssip_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// filling side
	input wire logic inValid,
	input wire logic [`SSIP_FRAME_BITS-1:0] inData,
	output logic inReady,
	// draining side
	input wire logic outReady,
	output logic outValid,
	output logic [`SSIP_FRAME_BITS-1:0] outData
);
	ssip_buf_t st_ff; // registered state
	ssip_buf_t nxt_st; // next state

	// entry 0 is always the oldest word, so the outputs come from flops
	assign outData = st_ff.mem[0];
	assign outValid = (st_ff.fill != 2'h0);
	assign inReady = (st_ff.fill != 2'h2);

	// push and pop; a pop shifts entry 1 down so no read pointer is needed
	always_comb
	begin
		logic doPush;
		logic doPop;
		doPush = 1'b0;
		doPop = 1'b0;
		nxt_st = st_ff;
		doPush = inValid && inReady;
		doPop = outReady && outValid;
		if (doPop)
		begin
			nxt_st.mem[0] = st_ff.mem[1];
		end
		if (doPush)
		begin
			// write lands behind whatever stays after the pop
			if (doPop)
				nxt_st.mem[st_ff.fill - 2'h1] = inData;
			else
				nxt_st.mem[st_ff.fill[0]] = inData;
		end
		nxt_st.fill = st_ff.fill + {1'b0, doPush} - {1'b0, doPop};
	end

	// state register
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			st_ff.mem <= '0;
			st_ff.fill <= 2'h0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end
endmodule

// ---- design/ssip_slave.sv ----
// slave end of a synchronous serial absolute position link
//
// Notes on behaviour
// - falling then rising clock starts frame, MSB first
// - each further rising edge presents next lower bit
// - extra clocks beyond the word shift out zeros
// - frame always carries 25 bit positions
// - after monoflop timeout latch position, data high
// - position field sent in Gray code
// - right aligned, zero padding leads, LSB last
// - field width 16, 17, 19 or 20 bits
// - one count equals one resolution step
// - no valid reading since power-on sends zero
// - read error freezes the last valid position
// - indicator lit while an error is active
// - zero-setting input makes current position zero
// - below zero the count wraps to maximum
// - direction input high reverses counting sense
`timescale 1ns/1ps
`include "ssip_map.svh"
module ssip_slave
	import ssip_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// serial link pins
	input wire logic sclk,
	output logic sdata,
	// control pins from the machine
	input wire logic zeroSetPin,
	input wire logic countDirPin,
	input wire logic [1:0] resSelPin,
	// absolute reading from the sensing front end, in resolution steps
	input wire logic [`SSIP_POS_BITS-1:0] rawPos,
	input wire logic rawValid,
	// status
	output logic errLed,
	output logic frameBusy
);
	import ssip_pkg::*;

	ssip_state_t st_ff; // registered state
	ssip_state_t nxt_st; // next state

	// frame buffer handshake
	logic bufInReady; // buffer has room for a latched frame
	logic bufOutValid; // a latched frame waits for the shifter
	logic [`SSIP_FRAME_BITS-1:0] bufOutData; // oldest latched frame
	logic bufPop; // shifter takes the oldest frame
	logic [`SSIP_FRAME_BITS-1:0] latchFrame; // frame built from held position

	// mask of valid position bits for a resolution code
	function automatic logic [`SSIP_POS_BITS-1:0] posMask(input logic [1:0] res);
		logic [4:0] w;
		w = `SSIP_WIDTH_STEP5;
		case (res)
			`SSIP_RES_STEP100: w = `SSIP_WIDTH_STEP100;
			`SSIP_RES_STEP50: w = `SSIP_WIDTH_STEP50;
			`SSIP_RES_STEP10: w = `SSIP_WIDTH_STEP10;
			default: w = `SSIP_WIDTH_STEP5;
		endcase
		posMask = ~({`SSIP_POS_BITS{1'b1}} << w);
	endfunction

	// Gray code of the field, right aligned with zero padding above it
	function automatic logic [`SSIP_FRAME_BITS-1:0] grayFrame(
		input logic [`SSIP_POS_BITS-1:0] pos);
		logic [`SSIP_POS_BITS-1:0] g;
		// pos is already masked, so the top padding stays zero after conversion
		g = pos ^ (pos >> 1);
		grayFrame = {{(`SSIP_FRAME_BITS-`SSIP_POS_BITS){1'b0}}, g};
	endfunction

	// what goes into the buffer at latch time; zero until a valid reading
	assign latchFrame = st_ff.validSeen ? grayFrame(st_ff.heldPos) : '0;

	// the shifter drains the buffer only on the falling edge that opens a frame
	assign bufPop = (st_ff.link == LNK_IDLE) && st_ff.sclkPrev && !st_ff.sclkSync;

	// outputs come straight from state flops
	assign sdata = st_ff.sdata;
	assign errLed = st_ff.errLed;
	assign frameBusy = st_ff.busy;

	// frame buffer: the latch stalls while it is full, so no word is dropped
	ssip_buffer u_buf (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.inValid(st_ff.pushReq),
		.inData(latchFrame),
		.inReady(bufInReady),
		.outReady(bufPop),
		.outValid(bufOutValid),
		.outData(bufOutData)
	);

	// next-state logic: synchronisers, position tracking and the link sequencer
	always_comb
	begin
		logic sclkRise;
		logic sclkFall;
		logic zeroRise;
		logic [`SSIP_POS_BITS-1:0] mask;
		logic [`SSIP_POS_BITS-1:0] rel;
		sclkRise = 1'b0;
		sclkFall = 1'b0;
		zeroRise = 1'b0;
		mask = '0;
		rel = '0;
		nxt_st = st_ff;

		// two-flop synchronisers; the first stage feeds only the second
		nxt_st.sclkMeta = sclk;
		nxt_st.sclkSync = st_ff.sclkMeta;
		nxt_st.sclkPrev = st_ff.sclkSync;
		nxt_st.zeroMeta = zeroSetPin;
		nxt_st.zeroSync = st_ff.zeroMeta;
		nxt_st.zeroPrev = st_ff.zeroSync;
		nxt_st.dirMeta = countDirPin;
		nxt_st.dirSync = st_ff.dirMeta;
		nxt_st.resMeta = resSelPin;
		nxt_st.resSync = st_ff.resMeta;

		// edges are found on the synchronised copies only
		sclkRise = st_ff.sclkSync && !st_ff.sclkPrev;
		sclkFall = !st_ff.sclkSync && st_ff.sclkPrev;
		zeroRise = st_ff.zeroSync && !st_ff.zeroPrev;
		mask = posMask(st_ff.resSync);

		// position relative to the zero point; modulo arithmetic gives the wrap
		if (st_ff.dirSync)
			rel = (st_ff.offset - rawPos) & mask;
		else
			rel = (rawPos - st_ff.offset) & mask;

		// position tracking: only a valid reading moves the held value
		if (rawValid)
		begin
			nxt_st.validSeen = 1'b1;
			if (zeroRise)
			begin
				// zero point is the present reading, whatever the direction
				nxt_st.offset = rawPos;
				nxt_st.heldPos = '0;
			end
			else
			begin
				// the count is in resolution steps, one per count
				nxt_st.heldPos = rel;
			end
		end
		// with rawValid low heldPos is left alone, so the last value is sent

		// indicator follows the error condition of the front end
		nxt_st.errLed = !rawValid;

		// link sequencer
		case (st_ff.link)
			LNK_LATCH:
			begin
				// idle high while the fresh frame waits for room in the buffer
				nxt_st.sdata = 1'b1;
				nxt_st.busy = 1'b0;
				if (st_ff.pushReq && bufInReady)
				begin
					nxt_st.pushReq = 1'b0;
					nxt_st.link = LNK_IDLE;
				end
			end
			LNK_IDLE:
			begin
				nxt_st.sdata = 1'b1;
				// first falling edge takes the latched frame; the line stays
				// high until the following rising edge
				if (sclkFall)
				begin
					nxt_st.shiftReg = bufOutValid ? bufOutData : '0;
					nxt_st.bitsLeft = `SSIP_CNT_BITS'(`SSIP_FRAME_BITS);
					nxt_st.monoCnt = '0;
					nxt_st.busy = 1'b1;
					nxt_st.link = LNK_SHIFT;
				end
			end
			LNK_SHIFT:
			begin
				if (sclkRise)
				begin
					nxt_st.monoCnt = '0;
					if (st_ff.bitsLeft != '0)
					begin
						// MSB on the first rising edge, then one lower bit per edge
						nxt_st.sdata = st_ff.shiftReg[st_ff.bitsLeft - 5'h1];
						nxt_st.bitsLeft = st_ff.bitsLeft - 5'h1;
					end
					else
					begin
						// the closing edge and any surplus edges send zeros
						nxt_st.sdata = 1'b0;
					end
				end
				else if (sclkFall)
				begin
					nxt_st.monoCnt = '0;
				end
				else if (st_ff.sclkSync)
				begin
					// clock parked high: run the monoflop, then latch a new frame
					if (st_ff.monoCnt == `SSIP_MONO_W'(`SSIP_LATCH_CYC - 1))
					begin
						nxt_st.pushReq = 1'b1;
						nxt_st.sdata = 1'b1;
						nxt_st.link = LNK_LATCH;
					end
					else
					begin
						nxt_st.monoCnt = st_ff.monoCnt + `SSIP_MONO_W'(1);
					end
				end
			end
			default:
			begin
				nxt_st.link = LNK_LATCH;
				nxt_st.pushReq = 1'b1;
			end
		endcase
	end

	// state register; reset latches a first frame straight away
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			st_ff.sclkMeta <= 1'b1;
			st_ff.sclkSync <= 1'b1;
			st_ff.sclkPrev <= 1'b1;
			st_ff.zeroMeta <= 1'b0;
			st_ff.zeroSync <= 1'b0;
			st_ff.zeroPrev <= 1'b0;
			st_ff.dirMeta <= 1'b0;
			st_ff.dirSync <= 1'b0;
			st_ff.resMeta <= 2'h0;
			st_ff.resSync <= 2'h0;
			st_ff.link <= LNK_LATCH;
			st_ff.bitsLeft <= '0;
			st_ff.monoCnt <= '0;
			st_ff.shiftReg <= '0;
			st_ff.sdata <= `SSIP_RST_SDATA;
			st_ff.offset <= '0;
			st_ff.heldPos <= '0;
			st_ff.validSeen <= 1'b0;
			st_ff.errLed <= `SSIP_RST_LED;
			st_ff.pushReq <= 1'b1;
			st_ff.busy <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end
endmodule

// ---- verification/ssip_master_model.sv ----
// behavioural link master: drives the link clock and gathers the serial word
`timescale 1ns/1ps
module ssip_master_model
(
	// link pins
	output logic sclk,
	input wire logic sdata
);
	// bench link period is 125 ns to keep runs short; slower field rates only
	// stretch each half period, which the slave tolerates above four system clocks
	localparam realtime halfPeriod = 62.5;

	// clock parks high outside frames
	initial sclk = 1'h1;

	// nClk falling and rising edges; sample just before each rise after the first
	task automatic read_frame(input int nClk, output logic [31:0] word);
		word = 32'h0;
		// step off the system clock edge the caller returned on
		#1;
		for (int i = 0; i < nClk; i++)
		begin
			sclk = 1'h0;
			#halfPeriod;
			if (i > 0)
				word = {word[30:0], sdata};
			sclk = 1'h1;
			#halfPeriod;
		end
	endtask
endmodule

// ---- verification/ssip_slave_asserts.sv ----
// port checks on the link slave
`timescale 1ns/1ps
`include "ssip_map.svh"
module ssip_slave_asserts
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// link and status
	input wire logic sclk,
	input wire logic sdata,
	input wire logic [1:0] resSelPin,
	input wire logic rawValid,
	input wire logic errLed,
	input wire logic frameBusy
);
	localparam int MONO_LO = `SSIP_LATCH_CYC - 8;
	localparam int MONO_HI = `SSIP_LATCH_CYC + 10;
	logic sclkQ_ff;
	logic [10:0] quietCnt_ff; // cycles since the link clock last moved
	logic [4:0] riseCnt_ff; // rises seen in this frame
	logic [4:0] widthLat_ff; // field width of the latched frame

	// width follows the strap at the moment a frame is latched, not at read
	always_ff @(posedge clk_sys)
	begin
		sclkQ_ff <= sclk;
		if (!resetn || sclk != sclkQ_ff)
			quietCnt_ff <= 11'h0;
		else if (quietCnt_ff != 11'h7ff)
			quietCnt_ff <= quietCnt_ff + 11'h1;
		if (!frameBusy)
			riseCnt_ff <= 5'h0;
		else if (sclk && !sclkQ_ff && riseCnt_ff != 5'h1f)
			riseCnt_ff <= riseCnt_ff + 5'h1;
		if (!resetn || $fell(frameBusy))
			widthLat_ff <= 5'h10 + 5'(resSelPin) + 5'(resSelPin[1]);
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	a_idle_high: assert property (!frameBusy |-> sdata)
		else $error("data line low while idle");
	a_err_tracks: assert property ($past(resetn) |-> errLed == !$past(rawValid))
		else $error("indicator does not follow reading state");
	a_shift_on_rise: assert property (frameBusy && $changed(sdata) |-> $past(sclk, 2) && $past(sclk, 3))
		else $error("data moved without a clock rise");
	a_fall_starts: assert property ($fell(sclk) && !frameBusy |-> ##[2:5] frameBusy)
		else $error("falling clock did not start a frame");
	a_monoflop_len: assert property ($fell(frameBusy) |-> quietCnt_ff >= MONO_LO && quietCnt_ff <= MONO_HI)
		else $error("frame end not one timeout after last edge");
	a_high_before_msb: assert property (frameBusy && riseCnt_ff == 5'h0 |-> sdata)
		else $error("data low before first rise");
	a_pad_zero: assert property (frameBusy && !sclk && riseCnt_ff != 5'h0 && riseCnt_ff <= 5'h19 - widthLat_ff |-> !sdata)
		else $error("padding bit not zero");
	a_extra_zero: assert property (frameBusy && !sclk && riseCnt_ff >= 5'h1a |-> !sdata)
		else $error("extra clock gave a one");

	c_frame_end: cover property ($fell(frameBusy));
	c_extra_clock: cover property (riseCnt_ff == 5'h1b);
	c_err_on: cover property ($rose(errLed));
endmodule

bind ssip_slave ssip_slave_asserts ssip_slave_asserts_inst (.clk_sys(clk_sys), .resetn(resetn),
	.sclk(sclk), .sdata(sdata), .resSelPin(resSelPin), .rawValid(rawValid), .errLed(errLed),
	.frameBusy(frameBusy));

// ---- verification/ssip_slave_tb_top.sv ----
// self-checking bench for the link slave with a behavioural master
`timescale 1ns/1ps
module ssip_slave_tb_top;
	import ssip_pkg::*;
	// strap, direction, reading and the position it should give
	typedef struct {logic [1:0] res; logic dir; logic [19:0] raw; logic [19:0] pos;} ssip_row_t;
	logic clk_sys = 1'h0;
	logic resetn = 1'h0;
	logic sclk;
	logic sdata;
	logic zeroSetPin = 1'h0;
	logic countDirPin = 1'h0;
	logic [1:0] resSelPin = 2'h0;
	logic [19:0] rawPos = 20'h0;
	logic rawValid = 1'h0;
	logic errLed;
	logic frameBusy;
	logic [31:0] word;
	int err_total = 0;
	int check_count = 0;
	// zero point is set at reading 0x100
	ssip_row_t rows[6] = '{'{2'h0, 1'h0, 20'h00105, 20'h00005},
		'{2'h0, 1'h0, 20'h000ff, 20'h0ffff}, '{2'h1, 1'h0, 20'h200ff, 20'h1ffff},
		'{2'h2, 1'h1, 20'h000f0, 20'h00010}, '{2'h3, 1'h0, 20'hfffff, 20'hffeff},
		'{2'h3, 1'h1, 20'h00101, 20'hfffff}};

	always #5 clk_sys = ~clk_sys;

	ssip_slave ssip_slave_inst (.clk_sys(clk_sys), .resetn(resetn), .sclk(sclk), .sdata(sdata),
		.zeroSetPin(zeroSetPin), .countDirPin(countDirPin), .resSelPin(resSelPin),
		.rawPos(rawPos), .rawValid(rawValid), .errLed(errLed), .frameBusy(frameBusy));
	ssip_master_model ssip_master_model_inst (.sclk(sclk), .sdata(sdata));

	function automatic logic [31:0] toGray(input logic [19:0] v);
		toGray = {12'h0, v ^ (v >> 1)};
	endfunction

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// wait out the timeout, then keep the pause between bursts
	task automatic idle_wait();
		int n;
		n = 0;
		while (frameBusy !== 1'h0 && n < 2000)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n == 2000)
		begin
			err_total++;
			wrap_up();
		end
		else
			repeat (2000) @(posedge clk_sys);
	endtask

	// one read, still busy inside the timeout, then line high once it ran out
	task automatic read_chk(input int nClk, input logic [31:0] exp);
		ssip_master_model_inst.read_frame(nClk, word);
		check_val(word, exp);
		check_val(32'(frameBusy), 32'h1);
		idle_wait();
		check_val(32'(sdata), 32'h1);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		repeat (3) @(posedge clk_sys);
		resetn <= 1'h1;
		@(posedge clk_sys);
		// look after the edge so the flops have settled
		#1;
		check_val(32'(errLed), 32'h1);
		check_val(32'(sdata), 32'h1);
		check_val(32'(frameBusy), 32'h0);
		repeat (5) @(posedge clk_sys);
		rawPos <= 20'h0007b;
		read_chk(26, 32'h0);
		read_chk(26, 32'h0);
		rawValid <= 1'h1;
		rawPos <= 20'h00100;
		zeroSetPin <= 1'h1;
		repeat (5) @(posedge clk_sys);
		zeroSetPin <= 1'h0;
		repeat (5) @(posedge clk_sys);
		check_val(32'(errLed), 32'h0);
		foreach (rows[i])
		begin
			resSelPin <= rows[i].res;
			countDirPin <= rows[i].dir;
			rawPos <= rows[i].raw;
			@(posedge clk_sys);
			ssip_master_model_inst.read_frame(26, word);
			idle_wait();
			read_chk(26, toGray(rows[i].pos));
		end
		read_chk(27, toGray(20'hfffff) << 1);
		rawValid <= 1'h0;
		rawPos <= 20'h00500;
		repeat (2) @(posedge clk_sys);
		check_val(32'(errLed), 32'h1);
		read_chk(26, toGray(20'hfffff));
		read_chk(26, toGray(20'hfffff));
		// mid-run reset: frozen value is dropped, zero sent until a valid reading
		resetn <= 1'h0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'h1;
		@(posedge clk_sys);
		#1;
		check_val(32'(errLed), 32'h1);
		check_val(32'(sdata), 32'h1);
		check_val(32'(frameBusy), 32'h0);
		repeat (5) @(posedge clk_sys);
		read_chk(26, 32'h0);
		wrap_up();
	end
endmodule
